// ---- logic/sio_buf_mem.sv ----
// Purpose: data buffer, one write port, two registered read ports
// Assumes: single clock, write and read in same cycle gives old data
// Notes:   no reset on the array
`timescale 1ns/1ps
module sio_buf_mem #(
  parameter int W     = 8,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // read ports
  input  wire logic [AW-1:0] raddr_a,
  output logic      [W-1:0]  rdata_a,
  input  wire logic [AW-1:0] raddr_b,
  output logic      [W-1:0]  rdata_b
);
  logic [W-1:0] mem_q [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_a <= '0;
      rdata_b <= '0;
    end else begin
      rdata_a <= mem_q[raddr_a];
      rdata_b <= mem_q[raddr_b];
    end
  end
endmodule // sio_buf_mem

// ---- logic/sio_ctrl.sv ----
// Purpose: buffered clocked synchronous serial controller, apb slave
// Assumes: clk_sys is the high-frequency clock, 100 MHz
// Notes:   apb side keeps running while ce is low
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "sio_regs.svh"

// ==========================================================
module sio_ctrl (
  // clock, enable, reset
  input  wire logic               clk_sys,
  input  wire logic               ce,
  input  wire logic               rst,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire sio_pkg::apb_addr_t paddr,
  input  wire sio_pkg::apb_data_t pwdata,
  input  wire logic [3:0]         pstrb,
  output sio_pkg::apb_data_t      prdata,
  output logic                    pready,
  output logic                    pslverr,
  // serial pins
  input  wire logic               sck_i,
  output logic                    sck_o,
  output logic                    sck_oe,
  input  wire logic               si,
  output logic                    so,
  // interrupt
  output logic                    irq
);
  import sio_pkg::*;

  // ========================================================
  // declarations
  state_t       state_q;
  logic         active_q;
  logic [2:0]   word_idx_q;
  logic [2:0]   bit_cnt_q;
  logic [6:0]   gap_cnt_q;
  logic [11:0]  div_cnt_q;
  byte_t        tx_sr_q;
  byte_t        rx_sr_q;
  logic         sck_q;
  logic         so_q;
  logic         sck_oe_q;
  logic         sck_m_q;
  logic         sck_s_q;
  logic         sck_d_q;
  logic         si_m_q;
  logic         si_s_q;
  logic         go_q;
  logic         abort_q;
  logic         arm_q;
  logic [2:0]   mode_q;
  logic [2:0]   clk_sel_q;
  logic [2:0]   cnt_q;
  logic [1:0]   wait_q;
  logic [1:0]   irq_en_q;
  logic [1:0]   irq_st_q;
  logic         irq_q;
  logic         rx_pend_q;
  logic [2:0]   rx_addr_q;
  byte_t        rx_data_q;
  logic         pready_q;
  logic         pslverr_q;
  apb_data_t    prdata_q;
  byte_t        rd_a;
  byte_t        rd_b;
  logic [13:0]  idx;
  logic         hit;
  logic         hs;
  logic         wr_ok;
  logic         wr_main;
  logic         wr_aux;
  logic         cpu_buf_wr;
  logic         ext_clk;
  logic         in_shift;
  logic         half_tick;
  logic         fall_ev;
  logic         rise_ev;
  logic         word_end;
  logic         last_word;
  logic         start_ok;
  logic         gap_on;
  logic         done_ev;
  logic [1:0]   irq_ev;
  logic [2:0]   last_bit;
  byte_t        rx_next;
  byte_t        rx_word;
  logic         mem_we;
  logic [2:0]   mem_waddr;
  byte_t        mem_wdata;
  apb_data_t    rd_val;

  // ========================================================
  // decode functions
  function automatic logic mode_ok(input logic [2:0] m);
    mode_ok = (m == `SIO_MODE_TX8) || (m == `SIO_MODE_TX4) ||
              (m == `SIO_MODE_TRX8) || (m == `SIO_MODE_RX8) ||
              (m == `SIO_MODE_RX4);
  endfunction

  function automatic logic mode_tx(input logic [2:0] m);
    mode_tx = (m == `SIO_MODE_TX8) || (m == `SIO_MODE_TX4) ||
              (m == `SIO_MODE_TRX8);
  endfunction

  function automatic logic mode_rx(input logic [2:0] m);
    mode_rx = (m == `SIO_MODE_TRX8) || (m == `SIO_MODE_RX8) ||
              (m == `SIO_MODE_RX4);
  endfunction

  function automatic logic mode_four(input logic [2:0] m);
    mode_four = (m == `SIO_MODE_TX4) || (m == `SIO_MODE_RX4);
  endfunction

  function automatic logic [11:0] div_mask(input logic [2:0] s);
    unique case (s)
      3'h0:    div_mask = `SIO_DIV_MASK13;
      3'h1:    div_mask = `SIO_DIV_MASK8;
      3'h2:    div_mask = `SIO_DIV_MASK7;
      3'h3:    div_mask = `SIO_DIV_MASK6;
      3'h4:    div_mask = `SIO_DIV_MASK5;
      default: div_mask = `SIO_DIV_MASK4;
    endcase
  endfunction

  function automatic logic [6:0] gap_halves(input logic [1:0] w);
    unique case (w)
      2'h0: gap_halves = 7'h00;
      2'h1: gap_halves = `SIO_GAP_W1;
      2'h2: gap_halves = `SIO_GAP_W2;
      2'h3: gap_halves = `SIO_GAP_W3;
    endcase
  endfunction

  // ========================================================
  // apb decode
  assign idx        = paddr[15:2];
  assign hit        = (paddr[1:0] == 2'h0) &&
                      (idx >= `SIO_IDX_AUX) && (idx <= `SIO_IDX_IRQ_CLR);
  assign hs         = psel && penable && pready_q;
  assign wr_ok      = hs && pwrite && hit && pstrb[0];
  // whole-byte writes only, no read-back to merge with
  assign wr_main    = wr_ok && (idx == `SIO_IDX_MAIN);
  assign wr_aux     = wr_ok && (idx == `SIO_IDX_AUX);
  assign cpu_buf_wr = wr_ok && (idx >= `SIO_IDX_BUF0) &&
                      (idx <= `SIO_IDX_BUF7);

  always_comb begin
    rd_val = '0;
    if (idx >= `SIO_IDX_BUF0 && idx <= `SIO_IDX_BUF7) begin
      rd_val[7:0] = rd_a;
    end else if (idx == `SIO_IDX_STATE) begin
      rd_val[`SIO_ST_ACTIVE] = active_q;
      rd_val[`SIO_ST_SHIFT]  = in_shift;
    end else if (idx == `SIO_IDX_IRQ_ST) begin
      rd_val[1:0] = irq_st_q;
    end else if (idx == `SIO_IDX_IRQ_EN) begin
      rd_val[1:0] = irq_en_q;
    end
  end

  // one wait state so buffer data come from the memory register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else if (psel && penable && !pready_q) begin
      pready_q  <= 1'b1;
      pslverr_q <= !hit;
      prdata_q  <= (pwrite || !hit) ? '0 : rd_val;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end
  end

  // ========================================================
  // control registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      go_q      <= 1'b0;
      mode_q    <= `SIO_MODE_TX8;
      clk_sel_q <= 3'h0;
    end else if (wr_main) begin
      go_q      <= pwdata[`SIO_MAIN_GO];
      mode_q    <= pwdata[`SIO_MAIN_MODE_HI:`SIO_MAIN_MODE_LO];
      clk_sel_q <= pwdata[`SIO_MAIN_CLK_HI:`SIO_MAIN_CLK_LO];
    end
  end

  // abort wins over a start written in the same byte
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      abort_q <= 1'b0;
    end else if (wr_main && pwdata[`SIO_MAIN_ABORT]) begin
      abort_q <= 1'b1;
    end else if (ce && abort_q) begin
      abort_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      arm_q <= 1'b0;
    end else if (wr_main) begin
      arm_q <= pwdata[`SIO_MAIN_GO] && !pwdata[`SIO_MAIN_ABORT];
    end else if (ce && (abort_q || start_ok)) begin
      arm_q <= 1'b0;
    end
  end

  // mode and clock changes assume software aborted first
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q  <= 3'h0;
      wait_q <= 2'h0;
    end else if (wr_aux) begin
      cnt_q  <= pwdata[`SIO_AUX_CNT_HI:`SIO_AUX_CNT_LO];
      wait_q <= pwdata[`SIO_AUX_WAIT_HI:`SIO_AUX_WAIT_LO];
    end
  end

  // ========================================================
  // pin synchronisers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sck_m_q <= 1'b1;
      sck_s_q <= 1'b1;
      sck_d_q <= 1'b1;
      si_m_q  <= 1'b1;
      si_s_q  <= 1'b1;
    end else if (ce) begin
      sck_m_q <= sck_i;
      sck_s_q <= sck_m_q;
      sck_d_q <= sck_s_q;
      si_m_q  <= si;
      si_s_q  <= si_m_q;
    end
  end

  // ========================================================
  // clock source and edges
  assign ext_clk   = (clk_sel_q == `SIO_CLK_EXT);
  assign in_shift  = (state_q == ST_SHIFT);
  assign half_tick = ((div_cnt_q & div_mask(clk_sel_q)) ==
                      div_mask(clk_sel_q));
  assign fall_ev   = in_shift && (ext_clk ? (sck_d_q && !sck_s_q) :
                                            (half_tick && sck_q));
  assign rise_ev   = in_shift && (ext_clk ? (!sck_d_q && sck_s_q) :
                                            (half_tick && !sck_q));
  assign last_bit  = mode_four(mode_q) ? `SIO_LAST_BIT4 : `SIO_LAST_BIT8;
  assign word_end  = rise_ev && (bit_cnt_q == last_bit);
  assign last_word = (word_idx_q == cnt_q);
  assign start_ok  = (state_q == ST_IDLE) && arm_q && !abort_q &&
                     mode_ok(mode_q) && (clk_sel_q != `SIO_CLK_RSVD);
  assign gap_on    = !ext_clk && (wait_q != 2'h0) &&
                     ((mode_q == `SIO_MODE_TRX8) ||
                      (mode_q == `SIO_MODE_RX8));
  assign rx_next   = {si_s_q, rx_sr_q[7:1]};
  assign rx_word   = mode_four(mode_q) ? {4'h0, rx_next[7:4]} :
                                         rx_next;

  // restarting at zero keeps the first half period full length
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_cnt_q <= 12'h000;
    end else if (ce) begin
      if (in_shift || state_q == ST_GAP) begin
        div_cnt_q <= div_cnt_q + 12'h001;
      end else begin
        div_cnt_q <= 12'h000;
      end
    end
  end

  // ========================================================
  // sequencer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q    <= ST_IDLE;
      active_q   <= 1'b0;
      word_idx_q <= 3'h0;
      bit_cnt_q  <= 3'h0;
      gap_cnt_q  <= 7'h00;
    end else if (ce) begin
      if (abort_q) begin
        state_q  <= ST_IDLE;
        active_q <= 1'b0;
      end else begin
        unique case (state_q)
          ST_IDLE: begin
            if (start_ok) begin
              state_q    <= ST_LOAD;
              active_q   <= 1'b1;
              word_idx_q <= 3'h0;
            end
          end
          ST_LOAD: state_q <= ST_FETCH;
          ST_FETCH: begin
            state_q   <= ST_SHIFT;
            bit_cnt_q <= 3'h0;
          end
          ST_SHIFT: begin
            if (rise_ev) begin
              bit_cnt_q <= bit_cnt_q + 3'h1;
            end
            if (word_end) begin
              word_idx_q <= last_word ? 3'h0 : word_idx_q + 3'h1;
              gap_cnt_q  <= 7'h00;
              if (last_word && !go_q) begin
                state_q  <= ST_IDLE;
                active_q <= 1'b0;
              end else if (gap_on) begin
                state_q <= ST_GAP;
              end else begin
                state_q <= ST_LOAD;
              end
            end
          end
          ST_GAP: begin
            if (half_tick) begin
              gap_cnt_q <= gap_cnt_q + 7'h01;
              if (gap_cnt_q == gap_halves(wait_q) - 7'h01) begin
                state_q <= ST_LOAD;
              end
            end
          end
        endcase
      end
    end
  end

  // ========================================================
  // shifter and pins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_sr_q  <= `SIO_RST_BYTE;
      rx_sr_q  <= `SIO_RST_BYTE;
      so_q     <= 1'b1;
      sck_q    <= 1'b1;
      sck_oe_q <= 1'b0;
    end else if (ce) begin
      sck_oe_q <= active_q && !ext_clk;
      if (state_q == ST_FETCH) begin
        tx_sr_q <= rd_b;
      end
      if (fall_ev) begin
        so_q    <= mode_tx(mode_q) ? tx_sr_q[0] : 1'b1;
        tx_sr_q <= {1'b0, tx_sr_q[7:1]};
      end else if (state_q == ST_IDLE) begin
        so_q <= 1'b1;
      end
      if (rise_ev) begin
        rx_sr_q <= rx_next;
      end
      if (!in_shift) begin
        sck_q <= 1'b1;
      end else if (!ext_clk && half_tick) begin
        sck_q <= !sck_q;
      end
    end
  end

  // ========================================================
  // buffer: received words wait one cycle behind a cpu write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_pend_q <= 1'b0;
      rx_addr_q <= 3'h0;
      rx_data_q <= `SIO_RST_BYTE;
    end else if (ce && word_end && mode_rx(mode_q) && !abort_q) begin
      rx_pend_q <= 1'b1;
      rx_addr_q <= word_idx_q;
      rx_data_q <= rx_word;
    end else if (!cpu_buf_wr) begin
      rx_pend_q <= 1'b0;
    end
  end

  assign mem_we    = cpu_buf_wr || rx_pend_q;
  assign mem_waddr = cpu_buf_wr ? idx[2:0] : rx_addr_q;
  assign mem_wdata = cpu_buf_wr ? pwdata[7:0] : rx_data_q;

  sio_buf_mem #(
    .W     (8),
    .DEPTH (8),
    .AW    (3)
  ) u_buf (
    .clk_sys (clk_sys),
    .rst     (rst),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .raddr_a (idx[2:0]),
    .rdata_a (rd_a),
    .raddr_b (word_idx_q),
    .rdata_b (rd_b)
  );

  // ========================================================
  // interrupt: set wins over clear
  assign done_ev = ce && word_end && last_word && !abort_q;
  assign irq_ev  = {ce && abort_q && active_q, done_ev};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_st_q <= `SIO_RST_IRQ;
      irq_en_q <= `SIO_RST_IRQ;
      irq_q    <= 1'b0;
    end else begin
      if (wr_ok && idx == `SIO_IDX_IRQ_CLR) begin
        irq_st_q <= (irq_st_q & ~pwdata[1:0]) | irq_ev;
      end else begin
        irq_st_q <= irq_st_q | irq_ev;
      end
      if (wr_ok && idx == `SIO_IDX_IRQ_EN) begin
        irq_en_q <= pwdata[1:0];
      end
      irq_q <= |(irq_st_q & irq_en_q);
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign sck_o   = sck_q;
  assign sck_oe  = sck_oe_q;
  assign so      = so_q;
  assign irq     = irq_q;

  // ========================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  irq_after_done_a: assert property (
    done_ev && irq_en_q[`SIO_IRQ_DONE] |-> ##[1:2] irq_q)
    else $error("done event did not raise irq");
  abort_stops_a: assert property (
    ce && abort_q |=> !active_q && state_q == ST_IDLE)
    else $error("abort left transfer active");
  abort_self_clr_a: assert property (
    ce && abort_q && !wr_main |=> !abort_q)
    else $error("abort bit not cleared");
  start_index_a: assert property (
    ce && start_ok && !abort_q |=> word_idx_q == 3'h0 && active_q)
    else $error("start did not reset index");
  index_bound_a: assert property (
    active_q |-> word_idx_q <= cnt_q || state_q == ST_IDLE)
    else $error("word index beyond count");
  lsb_first_a: assert property (
    ce && fall_ev && mode_tx(mode_q) |=> so_q == $past(tx_sr_q[0]))
    else $error("transmit bit order wrong");
  nibble_zero_a: assert property (
    rx_pend_q && mode_four(mode_q) |-> rx_data_q[7:4] == 4'h0)
    else $error("upper nibble not zero");
  sck_idle_high_a: assert property (
    ce && !in_shift |=> sck_q)
    else $error("serial clock not idle high");
  gap_mode_a: assert property (
    state_q == ST_GAP |-> gap_on)
    else $error("wait gap in wrong mode");
  start_mode_a: assert property (
    ce && state_q == ST_IDLE &&
    (!mode_ok(mode_q) || clk_sel_q == `SIO_CLK_RSVD) |=> state_q == ST_IDLE)
    else $error("start in reserved mode");
  div4_period_a: assert property (
    ce && in_shift && clk_sel_q == 3'h5 && $changed(sck_q) |=>
    ($stable(sck_q) || !in_shift || !ce)[*7])
    else $error("divide by 16 half period wrong");
  ext_no_drive_a: assert property (
    ce && ext_clk |=> !sck_oe_q)
    else $error("driving clock pin in external mode");

  done_c:  cover property (done_ev);
  abort_c: cover property (abort_q && in_shift);
  gap_c:   cover property (state_q == ST_GAP);
  ext_c:   cover property (ext_clk && word_end);
endmodule // sio_ctrl

// ---- logic/sio_pkg.sv ----
// Purpose: shared types of the serial controller
// Assumes: constants live in sio_regs.svh
// Notes:   types only
package sio_pkg;
  typedef logic [15:0] apb_addr_t;
  typedef logic [31:0] apb_data_t;
  typedef logic [7:0]  byte_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_LOAD, ST_FETCH, ST_SHIFT, ST_GAP
  } state_t;
endpackage

// ---- logic/sio_regs.svh ----
// Purpose: register indices, field positions, codes and counts
// Assumes: byte address = 4 * register index
// Notes:   definitions only
`ifndef SIO_REGS_SVH
`define SIO_REGS_SVH

// ==========================================================
// register indices (byte address = 4 * index)
`define SIO_IDX_AUX      14'h1f95
`define SIO_IDX_MAIN     14'h1f96
`define SIO_IDX_STATE    14'h1f97
`define SIO_IDX_BUF0     14'h1f98
`define SIO_IDX_BUF7     14'h1f9f
`define SIO_IDX_IRQ_ST   14'h1fa0
`define SIO_IDX_IRQ_EN   14'h1fa1
`define SIO_IDX_IRQ_CLR  14'h1fa2

// ==========================================================
// field positions
`define SIO_MAIN_GO      7
`define SIO_MAIN_ABORT   6
`define SIO_MAIN_MODE_HI 5
`define SIO_MAIN_MODE_LO 3
`define SIO_MAIN_CLK_HI  2
`define SIO_MAIN_CLK_LO  0
`define SIO_AUX_CNT_HI   2
`define SIO_AUX_CNT_LO   0
`define SIO_AUX_WAIT_HI  4
`define SIO_AUX_WAIT_LO  3
`define SIO_ST_ACTIVE    7
`define SIO_ST_SHIFT     6
`define SIO_IRQ_DONE     0
`define SIO_IRQ_ABORT    1

// ==========================================================
// reset values
`define SIO_RST_BYTE     8'h00
`define SIO_RST_IRQ      2'h0

// ==========================================================
// mode and clock codes
`define SIO_MODE_TX8     3'h0
`define SIO_MODE_TX4     3'h2
`define SIO_MODE_TRX8    3'h4
`define SIO_MODE_RX8     3'h5
`define SIO_MODE_RX4     3'h6
`define SIO_CLK_RSVD     3'h6
`define SIO_CLK_EXT      3'h7

// ==========================================================
// timing: half-period masks of high_freq_clock / 2^n
`define SIO_DIV_MASK13   12'hfff
`define SIO_DIV_MASK8    12'h07f
`define SIO_DIV_MASK7    12'h03f
`define SIO_DIV_MASK6    12'h01f
`define SIO_DIV_MASK5    12'h00f
`define SIO_DIV_MASK4    12'h007
// wait gap in half bit periods for Tf = 2, 4, 8 word times
`define SIO_GAP_W1       7'h10
`define SIO_GAP_W2       7'h30
`define SIO_GAP_W3       7'h70
`define SIO_LAST_BIT8    3'h7
`define SIO_LAST_BIT4    3'h3

`endif

// ---- tb/sio_ctrl_tb.sv ----
// Purpose: self-checking bench of the serial controller
// Assumes: apb answer is awaited, never counted
// Notes:   divider code 000 skipped, it would run too long
`timescale 1ns/1ps
`include "sio_regs.svh"
module sio_ctrl_tb;
  import sio_pkg::*;
  typedef struct {
    logic [2:0] mode, clk, cnt;
    logic [1:0] wt;
  } row_t;
  logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic ext_sck = 1, sel = 0, nib = 0, ce = 1, pready, pslverr;
  logic sck_o, sck_oe, si, so, irq;
  apb_addr_t paddr = 16'h0000;
  apb_data_t pwdata = 32'h0000_0000;
  apb_data_t prdata;
  logic [7:0] peer_rx;
  wire  sck_line = sck_oe ? sck_o : ext_sck;
  int failures = 0, checks = 0;
  row_t rows[8] = '{
    '{3'h0, 3'h5, 3'h0, 2'h0}, '{3'h2, 3'h5, 3'h1, 2'h0},
    '{3'h4, 3'h4, 3'h2, 2'h0}, '{3'h5, 3'h5, 3'h1, 2'h1},
    '{3'h6, 3'h3, 3'h7, 2'h0}, '{3'h0, 3'h1, 3'h0, 2'h0},
    '{3'h2, 3'h2, 3'h0, 2'h0}, '{3'h0, 3'h7, 3'h0, 2'h0}};
  always #5 clk_sys = ~clk_sys;
  sio_ctrl uut (.clk_sys(clk_sys), .ce(ce), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'h1), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sck_i(sck_line), .sck_o(sck_o), .sck_oe(sck_oe), .si(si), .so(so),
    .irq(irq));
  sio_peer peer (.sck(sck_line), .so(so), .si(si), .sel(sel), .nib(nib),
    .tx_byte(8'h1d), .rx_q(peer_rx));
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [13:0] idx,
                     input byte_t wd, output byte_t rd, output logic er);
    @(posedge clk_sys);
    psel <= 1; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= {24'h0, wd};
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata[7:0];
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic give_verdict;
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================
  // one programmed block, then data and irq checks
  task automatic run(input row_t r);
    byte_t rd, ex;
    logic  er;
    logic  rxm;
    nib <= r.mode[1];
    rxm = r.mode inside {3'h4, 3'h5, 3'h6};
    apb(1, `SIO_IDX_MAIN, {2'b01, r.mode, r.clk}, rd, er);
    apb(1, `SIO_IDX_AUX, {3'b000, r.wt, r.cnt}, rd, er);
    for (int k = 0; k < 8; k++) apb(1, 14'h1f98 + k, 8'h61 + k, rd, er);
    sel <= 1;
    apb(1, `SIO_IDX_MAIN, {2'b10, r.mode, r.clk}, rd, er);
    // go cleared at once: block ends after its count, no repeat
    apb(1, `SIO_IDX_MAIN, {2'b00, r.mode, r.clk}, rd, er);
    if (r.clk == `SIO_CLK_EXT) begin
      repeat (8) begin
        repeat (20) @(posedge clk_sys);
        ext_sck <= 0;
        repeat (20) @(posedge clk_sys);
        ext_sck <= 1;
      end
    end
    rd = 8'h80;
    while (rd[7] !== 1'b0) apb(0, `SIO_IDX_STATE, 8'h00, rd, er);
    sel <= 0;
    apb(0, `SIO_IDX_IRQ_ST, 8'h00, rd, er);
    chk(rd, 8'h01);
    chk(irq, 1'b1);
    apb(1, `SIO_IDX_IRQ_CLR, 8'h01, rd, er);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b0);
    for (int k = 0; k < 8; k++) begin
      apb(0, 14'h1f98 + k, 8'h00, rd, er);
      ex = (rxm && k <= r.cnt) ? (nib ? 8'h0d : 8'h1d) : 8'h61 + k;
      chk(rd, ex);
    end
    ex = 8'h61 + r.cnt;
    if (r.mode inside {3'h0, 3'h4}) chk(peer_rx, ex);
    if (r.mode == 3'h2) chk(peer_rx[7:4], ex[3:0]);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    byte_t rd;
    logic  er;
    logic  sck_seen;
    repeat (4) @(posedge clk_sys);
    rst <= 0;
    @(posedge clk_sys);
    chk({so, sck_o, sck_oe, irq}, 4'hc);
    apb(0, `SIO_IDX_STATE, 8'h00, rd, er);
    chk(rd, 8'h00);
    apb(0, 14'h1fa3, 8'h00, rd, er);
    chk({er, rd}, 9'h100);
    apb(1, `SIO_IDX_IRQ_EN, 8'h03, rd, er);
    foreach (rows[i]) run(rows[i]);
    // abort in mid-block
    apb(1, `SIO_IDX_MAIN, 8'h43, rd, er);
    apb(1, `SIO_IDX_AUX, 8'h07, rd, er);
    apb(1, `SIO_IDX_MAIN, 8'h83, rd, er);
    repeat (100) @(posedge clk_sys);
    chk(sck_oe, 1'b1);
    // enable low must hold the clock pin past a whole half period
    ce <= 0;
    @(posedge clk_sys);
    sck_seen = sck_o;
    repeat (40) @(posedge clk_sys);
    chk(sck_o, sck_seen);
    ce <= 1;
    apb(1, `SIO_IDX_MAIN, 8'h43, rd, er);
    repeat (3) @(posedge clk_sys);
    chk(sck_oe, 1'b0);
    apb(0, `SIO_IDX_STATE, 8'h00, rd, er);
    chk(rd[7], 1'b0);
    apb(0, `SIO_IDX_IRQ_ST, 8'h00, rd, er);
    chk(rd, 8'h02);
    // reserved mode and reserved clock must never start
    apb(1, `SIO_IDX_MAIN, 8'h4b, rd, er);
    apb(1, `SIO_IDX_MAIN, 8'h8b, rd, er);
    apb(0, `SIO_IDX_STATE, 8'h00, rd, er);
    chk(rd, 8'h00);
    apb(1, `SIO_IDX_MAIN, 8'h46, rd, er);
    apb(1, `SIO_IDX_MAIN, 8'h86, rd, er);
    apb(0, `SIO_IDX_STATE, 8'h00, rd, er);
    chk(rd, 8'h00);
    apb(0, `SIO_IDX_MAIN, 8'h00, rd, er);
    chk({er, rd}, 9'h000);
    give_verdict();
  end
  // cut a hang short, well past the longest expected run
  initial begin
    repeat (60000) @(posedge clk_sys);
    failures++;
    give_verdict();
  end
endmodule // sio_ctrl_tb

// ---- tb/sio_peer.sv ----
// Purpose: external clocked serial peripheral on the far side
// Assumes: sel high while a transfer is expected
// Notes:   one tx byte repeated; last shifted-in bits kept in rx_q
`timescale 1ns/1ps
// ==========================================================
// peer model
module sio_peer (
  // serial pins
  input  wire logic       sck,
  input  wire logic       so,
  output logic            si,
  // control
  input  wire logic       sel,
  input  wire logic       nib,
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_q
);
  logic [2:0] cnt_q;
  logic       bit_q;
  initial begin
    rx_q  = 8'h00;
    cnt_q = 3'h0;
    bit_q = 1'b1;
  end
  // released line shows the inverse so a stale value cannot pass
  assign si = sel ? bit_q : ~bit_q;
  always @(negedge sck or negedge sel) begin
    if (!sel) begin
      cnt_q <= 3'h0;
    end else begin
      bit_q <= tx_byte[cnt_q];
      cnt_q <= (nib && cnt_q == 3'h3) ? 3'h0 : cnt_q + 3'h1;
    end
  end
  always @(posedge sck) begin
    if (sel) rx_q <= {so, rx_q[7:1]};
  end
endmodule // sio_peer
